// file: spi_defines.vh
// register map, field positions and reset values of the serial shift unit
`ifndef SPI_DEFINES_VH
`define SPI_DEFINES_VH

// register indices; the byte address is four times the index
`define IDX_DATA 8'hE0
`define IDX_DIV 8'hE1
`define IDX_MODE 8'hE2
`define IDX_MISC 8'hDD

// serial_mode_control fields
`define MODE_ACTIVE 7
`define MODE_IRQ_EN 6
`define MODE_PHASE 5
`define MODE_BASE_CLK 4
`define MODE_IN_EN 3
`define MODE_EXT_START 2
`define MODE_FILT_DIS 1
`define MODE_POLARITY 0

// divider register fields
`define DIV_FLAG 7
`define DIV_LEN_HI 6
`define DIV_LEN_LO 3
`define DIV_CD_HI 2
`define DIV_CD_LO 0

// misc_output_select field
`define MISC_SEL 0

// reset values
`define RST_MODE 8'h00
`define RST_DIV 8'h00
`define RST_DATA 8'h00
`define RST_MISC 1'b0
`define RST_LEN 4'h0
`define RST_CD 3'h0

`endif

// file: spi_far_slave.sv
// far-side serial slave answering the master clock
`timescale 1ns/1ps
`default_nettype none
module spi_far_slave (
  // control from bench
  input wire logic load,
  input wire logic [7:0] tx_byte,
  // serial link
  input wire logic sck,
  input wire logic mosi,
  output var logic miso,
  output var logic [7:0] rx_byte
);
  logic [7:0] sh;
  assign miso = sh[7];
  always @(posedge sck)
    rx_byte <= {rx_byte[6:0], mosi};
  // past the last bit the line keeps toggling, never a stale value
  always @(negedge sck or posedge load)
    if (load)
      sh <= tx_byte;
    else
      sh <= {sh[6:0], ~sh[0]};
endmodule
`default_nettype wire

// file: spi_shift_mode_control.v
// serial shift unit with mode control, divider and ahb-lite register slave
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "spi_defines.vh"

module spi_shift_mode_control (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // serial clock pin
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe,
  // serial data pins
  input wire sin,
  output reg sout,
  output reg sout_oe,
  // port logic sharing the output pin and the request line
  input wire port_sout,
  input wire port_sout_oe,
  input wire port_irq,
  // shared interrupt request
  output reg irq
);

  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_SHIFT = 2'b10;

  // ****************************************************
  // registers
  // ****************************************************
  reg [7:0] mode;
  reg [3:0] frame_len;
  reg [2:0] clk_div;
  reg xfer_flag;
  reg misc_sel;
  reg [7:0] shreg;
  reg [1:0] state;
  reg [3:0] bit_cnt;
  reg [8:0] div_cnt;
  reg sck_gen;
  reg lvl_prev;
  reg out_bit;
  reg start_and_prev;
  reg wr_pend;
  reg [7:0] wr_idx;

  wire active = mode[`MODE_ACTIVE];
  wire polarity = mode[`MODE_POLARITY];
  wire phase = mode[`MODE_PHASE];
  wire master = mode[`MODE_BASE_CLK];

  // ****************************************************
  // input synchronisers and noise filters
  // ****************************************************
  wire [1:0] pin_raw = {sck_in, sin};
  wire [1:0] pin_f;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : filt
      reg s1;
      reg s2;
      reg s3;
      reg f;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          f <= 1'b0;
        end else begin
          s1 <= pin_raw[g];
          s2 <= s1;
          s3 <= s2;
          // unless MODE_FILT_DIS is set, filter keeps a level only once it is seen twice running
          if (mode[`MODE_FILT_DIS] || s2 == s3) begin
            f <= s2;
          end
        end
      end
      assign pin_f[g] = f;
    end
  endgenerate

  wire sin_f = pin_f[0];
  wire sck_f = pin_f[1];

  // ****************************************************
  // bus decode
  // ****************************************************
  wire addr_phase = hsel & hready & htrans[1];
  wire addr_hit = (haddr[31:10] == 22'h000000) &&
    (haddr[9:2] == `IDX_DATA || haddr[9:2] == `IDX_DIV ||
     haddr[9:2] == `IDX_MODE);
  wire wr_mode = wr_pend && wr_idx == `IDX_MODE;
  wire wr_div = wr_pend && wr_idx == `IDX_DIV;
  wire wr_data = wr_pend && wr_idx == `IDX_DATA;
  wire wr_misc = wr_pend && wr_idx == `IDX_MISC;

  reg [7:0] rd_val;
  always @* begin
    case (haddr[9:2])
      `IDX_DATA: rd_val = shreg;
      `IDX_DIV: rd_val = {xfer_flag, frame_len, clk_div};
      `IDX_MODE: rd_val = mode;
      default: rd_val = 8'h00;
    endcase
    if (!addr_hit) begin
      rd_val = 8'h00;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      if (addr_phase) begin
        wr_pend <= hwrite && haddr[31:10] == 22'h000000;
        wr_idx <= haddr[9:2];
        hrdata <= hwrite ? 32'h00000000 : {24'h000000, rd_val};
      end
    end
  end

  // ****************************************************
  // serial clock and edges
  // ****************************************************
  // half period of the master clock in hclk cycles
  reg [8:0] half_ratio;
  always @* begin
    case (clk_div)
      3'h0: half_ratio = 9'h001;
      3'h1: half_ratio = 9'h002;
      3'h2: half_ratio = 9'h004;
      3'h3: half_ratio = 9'h008;
      3'h4: half_ratio = 9'h010;
      3'h5: half_ratio = 9'h020;
      3'h6: half_ratio = 9'h040;
      default: half_ratio = 9'h100;
    endcase
  end

  wire in_shift = state == ST_SHIFT;
  wire level = master ? sck_gen : sck_f;
  wire lead = in_shift && lvl_prev == polarity && level != polarity;
  wire trail = in_shift && lvl_prev != polarity && level == polarity;
  wire din = mode[`MODE_IN_EN] ? sin_f : 1'b0;
  wire [3:0] cnt_inc = bit_cnt + 4'h1;
  // a completed frame closes on a trailing edge so the clock ends idle
  wire done = trail && (phase ? cnt_inc == frame_len
                               : bit_cnt == frame_len);
  wire start_and = active & sin_f;
  wire ext_start = start_and & ~start_and_prev;
  wire go_shift = (state == ST_IDLE && active &&
                   !mode[`MODE_EXT_START]) ||
                  (state == ST_WAIT && active && ext_start);
  // software clearing the run bit mid-frame counts as a frame end
  wire abort = wr_mode && !hwdata[`MODE_ACTIVE] &&
               state != ST_IDLE;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 9'h000;
      sck_gen <= 1'b0;
      lvl_prev <= 1'b0;
      start_and_prev <= 1'b0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
    end else begin
      lvl_prev <= level;
      // the start edge is only armed while waiting, so a level that
      // is already high when the wait begins still counts as a rise
      start_and_prev <= (state == ST_WAIT) ? start_and : 1'b0;
      sck_oe <= master;
      sck_out <= sck_gen;
      if (in_shift && master && !done) begin
        if (div_cnt == half_ratio - 9'h001) begin
          div_cnt <= 9'h000;
          sck_gen <= ~sck_gen;
        end else begin
          div_cnt <= div_cnt + 9'h001;
        end
      end else begin
        div_cnt <= 9'h000;
        sck_gen <= polarity;
      end
    end
  end

  // ****************************************************
  // frame control and shift register
  // ****************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= `RST_DATA;
      out_bit <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (active && mode[`MODE_EXT_START]) begin
            state <= ST_WAIT;
          end else if (go_shift) begin
            state <= ST_SHIFT;
          end
          bit_cnt <= 4'h0;
        end
        ST_WAIT: begin
          if (!active) begin
            state <= ST_IDLE;
          end else if (go_shift) begin
            state <= ST_SHIFT;
          end
          bit_cnt <= 4'h0;
        end
        ST_SHIFT: begin
          if (!active || done) begin
            state <= ST_IDLE;
          end
          if (phase) begin
            if (lead) begin
              out_bit <= shreg[7];
            end
            if (trail) begin
              shreg <= {shreg[6:0], din};
              bit_cnt <= cnt_inc;
            end
          end else begin
            if (lead) begin
              shreg <= {shreg[6:0], din};
              bit_cnt <= cnt_inc;
            end
            if (trail) begin
              out_bit <= shreg[7];
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (wr_data && !active) begin
        shreg <= hwdata[7:0];
        if (!phase) begin
          out_bit <= hwdata[7];
        end
      end
    end
  end

  // ****************************************************
  // control registers
  // ****************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= `RST_MODE;
      // divider fields come up cleared
      frame_len <= `RST_LEN;
      clk_div <= `RST_CD;
      xfer_flag <= 1'b0;
      misc_sel <= `RST_MISC;
    end else begin
      if (wr_mode) begin
        mode <= hwdata[7:0];
      end else if (done && in_shift) begin
        mode[`MODE_ACTIVE] <= 1'b0;
      end
      if (wr_div && !active) begin
        frame_len <= hwdata[`DIV_LEN_HI:`DIV_LEN_LO];
        clk_div <= hwdata[`DIV_CD_HI:`DIV_CD_LO];
      end
      // a new end of frame wins over a clear in the same cycle
      if ((done && in_shift) || abort) begin
        xfer_flag <= 1'b1;
      end else if (wr_div && !hwdata[`DIV_FLAG]) begin
        xfer_flag <= 1'b0;
      end
      if (wr_misc) begin
        misc_sel <= hwdata[`MISC_SEL];
      end
    end
  end

  // ****************************************************
  // pins and request
  // ****************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sout <= 1'b0;
      sout_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      sout <= misc_sel ? out_bit : port_sout;
      sout_oe <= misc_sel ? 1'b1 : port_sout_oe;
      // port request shares the line, so it is ORed in unmasked
      irq <= (xfer_flag & mode[`MODE_IRQ_EN]) | port_irq;
    end
  end

endmodule
`default_nettype wire

// file: spi_shift_mode_control_bench.sv
// self-checking bench for the serial shift unit
`timescale 1ns/1ps
`default_nettype none
`include "spi_defines.vh"
module spi_shift_mode_control_bench;
  localparam logic [31:0] A_DATA = {22'h0, `IDX_DATA, 2'h0};
  localparam logic [31:0] A_DIV = {22'h0, `IDX_DIV, 2'h0};
  localparam logic [31:0] A_MODE = {22'h0, `IDX_MODE, 2'h0};
  localparam logic [31:0] A_MISC = {22'h0, `IDX_MISC, 2'h0};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, load;
  logic sck_out, sck_oe, sin, sout, sout_oe, irq;
  logic port_sout, port_sout_oe, port_irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] rx_byte, tx_byte;
  int n_fail, n_tests, cyc;
  spi_shift_mode_control dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sck_in(1'b0),
    .sck_out(sck_out), .sck_oe(sck_oe), .sin(sin), .sout(sout),
    .sout_oe(sout_oe), .port_sout(port_sout),
    .port_sout_oe(port_sout_oe), .port_irq(port_irq), .irq(irq));
  spi_far_slave far (.load(load), .tx_byte(tx_byte), .sck(sck_out),
    .mosi(sout), .miso(sin), .rx_byte(rx_byte));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic end_sim;
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (exp !== got) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one single-word transfer, read data left in rd
  task automatic bus(input logic wr, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, port_sout, port_sout_oe, port_irq} = 6'h00;
    {htrans, haddr, hwdata, tx_byte} = 74'h0;
    {n_fail, n_tests, cyc} = 0;
    load = 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    load <= 1'b0;
    @(posedge hclk);
    bus(0, A_MODE, 0); chk("mode reset", 32'h00, rd);
    bus(0, 32'h0, 0); chk("unmapped", 32'h00, rd);
    {port_sout, port_sout_oe, port_irq} <= 3'h7;
    repeat (2) @(posedge hclk);
    chk("port pin", 3'h7, {sout, sout_oe, irq});
    {port_sout, port_sout_oe, port_irq} <= 3'h0;
    bus(1, A_MISC, 32'h01);
    bus(1, A_DATA, 32'hA5);
    repeat (2) @(posedge hclk);
    chk("first bit", 2'h3, {sout_oe, sout});
    tx_byte <= 8'h3C;
    load <= 1'b1;
    @(posedge hclk);
    load <= 1'b0;
    bus(1, A_DIV, 32'h43); // eight bits, half period eight cycles
    bus(1, A_MODE, 32'hD8);
    repeat (60) @(posedge hclk);
    bus(1, A_DATA, 32'hFF);
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge hclk);
    chk("irq", 1'b1, irq);
    chk("far rx", 8'hA5, rx_byte);
    bus(0, A_DATA, 0); chk("data", 32'h3C, rd);
    bus(0, A_MODE, 0); chk("mode done", 32'h58, rd);
    bus(0, A_DIV, 0); chk("div flag", 32'hC3, rd);
    bus(1, A_DIV, 32'h23); // four-bit frames, flag cleared
    repeat (2) @(posedge hclk);
    chk("irq clear", 1'b0, irq);
    bus(1, A_DATA, 32'h5A);
    tx_byte <= 8'hC0;
    load <= 1'b1;
    @(posedge hclk);
    load <= 1'b0;
    bus(1, A_MODE, 32'h98);
    rd = 32'h80;
    for (int i = 0; i < 60 && rd[7]; i++) bus(0, A_MODE, 0);
    chk("short frame done", 32'h18, rd);
    bus(0, A_DATA, 0); chk("short data", 32'hAC, rd);
    bus(0, A_DIV, 0); chk("short flag", 32'hA3, rd);
    chk("masked irq", 1'b0, irq);
    bus(1, A_DIV, 32'h43);
    bus(1, A_MODE, 32'hD8);
    repeat (20) @(posedge hclk);
    bus(1, A_MODE, 32'h58);
    repeat (20) @(posedge hclk);
    chk("abort", 2'h2, {irq, sck_out});
    bus(0, A_DIV, 0); chk("abort flag", 32'hC3, rd);
    tx_byte <= 8'h80;
    load <= 1'b1;
    @(posedge hclk);
    load <= 1'b0;
    bus(1, A_MODE, 32'h94);
    rd = 32'h80;
    for (int i = 0; i < 150 && rd[7]; i++) bus(0, A_MODE, 0);
    chk("ext start done", 32'h14, rd);
    end_sim();
  end
endmodule
`default_nettype wire

// file: spi_shift_props.sv
// assertion checker for the serial shift unit, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module spi_shift_props (
  // clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins and shared lines
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic sout,
  input wire logic sout_oe,
  input wire logic port_sout,
  input wire logic port_sout_oe,
  input wire logic port_irq,
  input wire logic irq
);
  logic wr_pend;
  logic misc_sel;
  logic [11:0] wr_addr;
  logic [7:0] mode_q;
  logic [2:0] ratio_q;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ***************************
  // shadow of software writes
  // ***************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      mode_q <= 8'h00;
      ratio_q <= 3'h0;
      misc_sel <= 1'b0;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr[11:0];
      if (wr_pend && wr_addr == 12'h388)
        mode_q <= hwdata[7:0];
      if (wr_pend && wr_addr == 12'h384)
        ratio_q <= hwdata[2:0];
      if (wr_pend && wr_addr == 12'h374)
        misc_sel <= hwdata[0];
    end
  end
  // ***************************
  // assertions
  // ***************************
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  read_width_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  sel_drive_a: assert property ($past(misc_sel) |-> sout_oe)
    else $error("shift output not driving pin");
  port_pass_a: assert property (!$past(misc_sel) |->
    sout == $past(port_sout) && sout_oe == $past(port_sout_oe))
    else $error("port does not own output pin");
  clock_drive_a: assert property (sck_oe == $past(mode_q[4]))
    else $error("clock pin direction wrong");
  irq_mask_a: assert property (!$past(mode_q[6]) && !$past(port_irq)
    |-> !irq)
    else $error("masked request seen");
  port_share_a: assert property ($past(port_irq) |-> irq)
    else $error("port request lost");
  sck_half_a: assert property ($fell(sck_out) && ratio_q == 3'h3
    && !mode_q[0] |=> !sck_out [*7])
    else $error("master clock low phase too short");
  cover property ($rose(irq));
  cover property ($fell(sck_out));
  cover property (misc_sel && sout_oe);
endmodule
bind spi_shift_mode_control spi_shift_props chk (.*);
`default_nettype wire
